/* pkg/sadc_regs.vh */
// Register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses (one 32-bit word each)
// ----------------------------------------------------------------
`define SADC_OFS_INPUT_SEL    5'h00
`define SADC_OFS_CTRL_A       5'h04
`define SADC_OFS_CTRL_B       5'h08
`define SADC_OFS_RESULT_LOW   5'h0C

// A separate word keeps the high byte read distinct from the low byte read
`define SADC_OFS_RESULT_HIGH  5'h10
`define SADC_OFS_STATUS       5'h14

// ----------------------------------------------------------------
// Input select register fields
// ----------------------------------------------------------------
`define SADC_REF_LSB          6
`define SADC_REF_VCC          2'h0
`define SADC_REF_EXT          2'h1
`define SADC_REF_INT          2'h2
`define SADC_TEMP_SENSOR      6'h22

// ----------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------
`define SADC_CA_ENABLE        7
`define SADC_CA_START         6
`define SADC_CA_AUTO          5
`define SADC_CA_DONE          4

// ----------------------------------------------------------------
// Control B fields
// ----------------------------------------------------------------
`define SADC_CB_LEFT          4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SADC_RST_BYTE         8'h00

// ----------------------------------------------------------------
// Conversion timing in half ADC clock cycles; trigger sync delay in CPU cycles
// ----------------------------------------------------------------
`define SADC_HALF_NORMAL      6'd26
`define SADC_HALF_FIRST       6'd50
`define SADC_HALF_AUTO        6'd27
`define SADC_HALF_SMP_NORMAL  6'd3
`define SADC_HALF_SMP_FIRST   6'd29
`define SADC_HALF_SMP_AUTO    6'd4
`define SADC_TRIG_SYNC        2'd3

`endif

/* logic/sadc_sequencer.v */
// Control and sequencing logic of a 10-bit successive-approximation converter
`timescale 1ns/100ps
`include "sadc_regs.vh"

module sadc_sequencer #(
   parameter TRIG_WIDTH = 8
) (
   // Clock and reset
   input  wire                  sys_clk,
   input  wire                  rst_n,
   // Avalon-MM slave
   input  wire [4:0]            avs_address,
   input  wire                  avs_read,
   input  wire                  avs_write,
   input  wire [31:0]           avs_writedata,
   input  wire [3:0]            avs_byteenable,
   output reg  [31:0]           avs_readdata,
   output reg                   avs_waitrequest,
   // Trigger sources: on-chip interrupt flags
   input  wire [TRIG_WIDTH-1:0] trig_flags,
   // Analog front end
   input  wire                  cmp_result,
   output reg  [1:0]            afe_ref_sel,
   output reg  [5:0]            afe_input_sel,
   output reg                   afe_gain_20x,
   output reg                   afe_gain_bypass,
   output reg                   afe_temp_sel,
   output reg                   afe_enable,
   output reg                   afe_sample,
   output reg  [9:0]            afe_dac_code,
   // Events
   output reg                   conv_done_pulse
);

   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_CONV = 3'b100;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [7:0]  input_select_reg;
   reg [7:0]  ctrl_a_reg;
   reg [7:0]  ctrl_b_reg;
   reg [9:0]  result_reg;
   reg        lock_reg;
   reg [2:0]  state_reg;
   reg [7:0]  presc_reg;
   reg [5:0]  half_reg;
   reg [5:0]  len_reg;
   reg [5:0]  smp_reg;
   reg        first_reg;
   reg        auto_conv_reg;
   reg [9:0]  sar_reg;
   reg [3:0]  bit_reg;
   reg        trig_prev_reg;
   reg [1:0]  sync_reg;
   reg        sync_busy_reg;
   reg        ack_reg;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire       en        = ctrl_a_reg[`SADC_CA_ENABLE];
   wire       auto_en   = ctrl_a_reg[`SADC_CA_AUTO];
   wire [2:0] div_sel   = ctrl_a_reg[2:0];
   wire [2:0] trig_sel  = ctrl_b_reg[2:0];
   wire       left_adj  = ctrl_b_reg[`SADC_CB_LEFT];
   wire       busy      = (state_reg != ST_IDLE);
   wire       req       = (avs_read | avs_write) & ~ack_reg;
   wire       wr_hit    = avs_write & ~ack_reg & avs_byteenable[0];
   wire       rd_hit    = avs_read & ~ack_reg;

   // Divider factor of 2, 4 .. 128; select 0 behaves like 1 so that factor is still 2
   function [7:0] div_mask;
      input [2:0] sel;
      begin
         div_mask = (sel == 3'd0) ? 8'h01 : ((8'h01 << sel) - 8'h01);
      end
   endfunction

   function [7:0] lane0;
      input [31:0] d;
      begin
         lane0 = d[7:0];
      end
   endfunction

   wire [7:0] mask      = div_mask(div_sel);
   // One CPU cycle per half ADC clock edge
   wire       half_tick = en & ((presc_reg & (mask >> 1)) == (mask >> 1));

   wire       trig_sig  = (trig_sel < TRIG_WIDTH) ? trig_flags[trig_sel] : 1'b0;
   wire       trig_rise = trig_sig & ~trig_prev_reg;
   wire       done_src  = (trig_sel == 3'd0);
   wire       sw_start  = wr_hit && (avs_address == `SADC_OFS_CTRL_A) &&
                          avs_writedata[`SADC_CA_START] && avs_writedata[`SADC_CA_ENABLE];
   wire       last_half = (half_reg == len_reg - 6'd1);
   wire       finish    = (state_reg == ST_CONV) && half_tick && last_half;
   wire       rising    = half_tick & ~presc_reg[7] & (presc_reg == mask);

   // Selection follows software outside the conversion state (idle or waiting) or in its final ADC clock
   wire       sel_open  = (state_reg != ST_CONV) ||
                          (half_reg >= len_reg - 6'd2);

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, then answer
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         ack_reg         <= req;
         avs_waitrequest <= ~req;
         if (rd_hit) begin
            case (avs_address)
               `SADC_OFS_INPUT_SEL:   avs_readdata <= {24'h0, input_select_reg};
               `SADC_OFS_CTRL_A:      avs_readdata <= {24'h0, ctrl_a_reg[7],
                                                       busy | ctrl_a_reg[6],
                                                       ctrl_a_reg[5:0]};
               `SADC_OFS_CTRL_B:      avs_readdata <= {24'h0, ctrl_b_reg};
               `SADC_OFS_RESULT_LOW:  avs_readdata <= left_adj ?
                                         {24'h0, result_reg[1:0], 6'h00} :
                                         {24'h0, result_reg[7:0]};
               `SADC_OFS_RESULT_HIGH: avs_readdata <= left_adj ?
                                         {24'h0, result_reg[9:2]} :
                                         {30'h0, result_reg[9:8]};
               `SADC_OFS_STATUS:      avs_readdata <= {29'h0, lock_reg, first_reg, busy};
               default:               avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers and result lock
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         input_select_reg <= `SADC_RST_BYTE;
         ctrl_a_reg       <= `SADC_RST_BYTE;
         ctrl_b_reg       <= `SADC_RST_BYTE;
         result_reg       <= 10'h000;
         lock_reg         <= 1'b0;
      end else begin
         if (wr_hit && avs_address == `SADC_OFS_INPUT_SEL)
            input_select_reg <= lane0(avs_writedata);
         if (wr_hit && avs_address == `SADC_OFS_CTRL_B)
            ctrl_b_reg <= lane0(avs_writedata);
         if (wr_hit && avs_address == `SADC_OFS_CTRL_A) begin
            ctrl_a_reg[7]   <= avs_writedata[7];
            ctrl_a_reg[5]   <= avs_writedata[5];
            ctrl_a_reg[3:0] <= avs_writedata[3:0];
         end
         // Start bit mirrors conversion activity
         if (sw_start)
            ctrl_a_reg[`SADC_CA_START] <= 1'b1;
         else if (!en || finish)
            ctrl_a_reg[`SADC_CA_START] <= 1'b0;
         // Done flag: set wins over write-one-to-clear
         if (finish)
            ctrl_a_reg[`SADC_CA_DONE] <= 1'b1;
         else if (wr_hit && avs_address == `SADC_OFS_CTRL_A && avs_writedata[`SADC_CA_DONE])
            ctrl_a_reg[`SADC_CA_DONE] <= 1'b0;
         if (rd_hit && avs_address == `SADC_OFS_RESULT_LOW)
            lock_reg <= 1'b1;
         else if (rd_hit && avs_address == `SADC_OFS_RESULT_HIGH)
            lock_reg <= 1'b0;
         if (finish && !lock_reg)
            result_reg <= sar_reg;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and trigger edge detection
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         presc_reg     <= 8'h00;
         trig_prev_reg <= 1'b0;
         sync_reg      <= 2'd0;
         sync_busy_reg <= 1'b0;
      end else begin
         trig_prev_reg <= trig_sig;
         if (!en)
            presc_reg <= 8'h00;
         else if (trig_rise && auto_en && !busy && !done_src)
            presc_reg <= 8'h00;
         else
            presc_reg <= (presc_reg + 8'h01) & mask;
         // Trigger edge is held for the synchroniser delay before starting
         if (trig_rise && auto_en && en && !busy && !sync_busy_reg && !done_src) begin
            sync_busy_reg <= 1'b1;
            sync_reg      <= 2'd1;
         end else if (sync_busy_reg) begin
            if (sync_reg == `SADC_TRIG_SYNC - 2'd1)
               sync_busy_reg <= 1'b0;
            sync_reg <= sync_reg + 2'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg       <= ST_IDLE;
         half_reg        <= 6'd0;
         len_reg         <= `SADC_HALF_NORMAL;
         smp_reg         <= `SADC_HALF_SMP_NORMAL;
         first_reg       <= 1'b1;
         auto_conv_reg   <= 1'b0;
         sar_reg         <= 10'h000;
         bit_reg         <= 4'd9;
         afe_sample      <= 1'b0;
         afe_dac_code    <= 10'h000;
         conv_done_pulse <= 1'b0;
      end else begin
         conv_done_pulse <= finish;
         afe_sample      <= 1'b0;
         // A start written together with the enable bit must not be lost
         if (!en && !sw_start) begin
            state_reg <= ST_IDLE;
            first_reg <= 1'b1;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (sw_start) begin
                     state_reg     <= ST_WAIT;
                     auto_conv_reg <= 1'b0;
                  end else if (sync_busy_reg && sync_reg == `SADC_TRIG_SYNC - 2'd1) begin
                     state_reg     <= ST_CONV;
                     auto_conv_reg <= 1'b1;
                     half_reg      <= 6'd0;
                     len_reg       <= first_reg ? `SADC_HALF_FIRST : `SADC_HALF_AUTO;
                     smp_reg       <= first_reg ? `SADC_HALF_SMP_FIRST : `SADC_HALF_SMP_AUTO;
                  end
               end
               ST_WAIT: begin
                  if (rising) begin
                     state_reg <= ST_CONV;
                     half_reg  <= 6'd0;
                     len_reg   <= first_reg ? `SADC_HALF_FIRST : `SADC_HALF_NORMAL;
                     smp_reg   <= first_reg ? `SADC_HALF_SMP_FIRST :
                                              `SADC_HALF_SMP_NORMAL;
                  end
               end
               ST_CONV: begin
                  if (half_tick) begin
                     half_reg <= half_reg + 6'd1;
                     if (half_reg == smp_reg - 6'd1) begin
                        afe_sample   <= 1'b1;
                        sar_reg      <= 10'h000;
                        bit_reg      <= 4'd9;
                        afe_dac_code <= 10'h200;
                     end else if (half_reg >= smp_reg && half_reg[0] && bit_reg != 4'hF) begin
                        // One decision per ADC clock after the hold, MSB first
                        sar_reg      <= cmp_result ? (afe_dac_code) :
                                        (afe_dac_code & ~(10'h001 << bit_reg));
                        if (bit_reg != 4'd0)
                           afe_dac_code <= (cmp_result ? afe_dac_code :
                                           (afe_dac_code & ~(10'h001 << bit_reg))) |
                                           (10'h001 << (bit_reg - 4'd1));
                        bit_reg      <= bit_reg - 4'd1;
                     end
                     if (last_half) begin
                        first_reg <= 1'b0;
                        half_reg  <= 6'd0;
                        // Done-flag source restarts regardless of the flag
                        if (auto_en && done_src) begin
                           state_reg <= ST_CONV;
                           len_reg   <= `SADC_HALF_NORMAL;
                           smp_reg   <= `SADC_HALF_SMP_NORMAL;
                        end else
                           state_reg <= ST_IDLE;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Buffered selection to the analog front end
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         afe_ref_sel     <= `SADC_REF_VCC;
         afe_input_sel   <= 6'h00;
         afe_gain_20x    <= 1'b0;
         afe_gain_bypass <= 1'b1;
         afe_temp_sel    <= 1'b0;
         afe_enable      <= 1'b0;
      end else begin
         afe_enable <= en;
         if (en && sel_open) begin
            afe_ref_sel     <= input_select_reg[`SADC_REF_LSB+1:`SADC_REF_LSB];
            afe_input_sel   <= input_select_reg[5:0];
            afe_temp_sel    <= (input_select_reg[5:0] == `SADC_TEMP_SENSOR);
            // Codes 0..7 are single-ended; others except the sensor are differential
            afe_gain_bypass <= (input_select_reg[5:3] == 3'd0) ||
                               (input_select_reg[5:0] == `SADC_TEMP_SENSOR);
            afe_gain_20x    <= (input_select_reg[5:3] != 3'd0) &&
                               (input_select_reg[5:0] != `SADC_TEMP_SENSOR) &&
                               input_select_reg[0];
         end
      end
   end

endmodule

/* verification/sadc_seq_chk.sv */
// Port-level assertions for the converter sequencer
`timescale 1ns/100ps
`include "sadc_regs.vh"

module sadc_seq_chk #(
   parameter TRIG_WIDTH = 8
) (
   // Clock and reset
   input wire                  sys_clk,
   input wire                  rst_n,
   // Register bus
   input wire [4:0]            avs_address,
   input wire                  avs_read,
   input wire                  avs_write,
   input wire [31:0]           avs_writedata,
   input wire [3:0]            avs_byteenable,
   input wire [31:0]           avs_readdata,
   input wire                  avs_waitrequest,
   // Triggers and front end
   input wire [TRIG_WIDTH-1:0] trig_flags,
   input wire                  cmp_result,
   input wire [1:0]            afe_ref_sel,
   input wire [5:0]            afe_input_sel,
   input wire                  afe_gain_20x,
   input wire                  afe_gain_bypass,
   input wire                  afe_temp_sel,
   input wire                  afe_enable,
   input wire                  afe_sample,
   input wire [9:0]            afe_dac_code,
   input wire                  conv_done_pulse
);
   // ----------------------------------------------------------------
   // Sequences and properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_req_idle;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   // Enable write taking effect at its acknowledge edge
   sequence s_en_wr(bit v);
      avs_write && !avs_waitrequest && avs_address == `SADC_OFS_CTRL_A
         && avs_byteenable[0] && avs_writedata[`SADC_CA_ENABLE] == v;
   endsequence

   a_wait_answer: assert property (s_req_idle |=> !avs_waitrequest)
      else $error("waitrequest did not drop one cycle after request");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 5'h18
      |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_enable_on: assert property (s_en_wr(1'b1) |-> ##[1:2] afe_enable)
      else $error("front end not enabled after enable write");
   a_enable_off: assert property (s_en_wr(1'b0) |-> ##[1:2] !afe_enable)
      else $error("front end still enabled after disable write");
   a_done_single: assert property (conv_done_pulse |=> !conv_done_pulse)
      else $error("done pulse longer than one cycle");
   a_sample_single: assert property (afe_sample |=> !afe_sample)
      else $error("sample pulse longer than one cycle");
   a_gain_bypass: assert property (afe_input_sel[5:3] == 3'h0
      || afe_input_sel == `SADC_TEMP_SENSOR |-> afe_gain_bypass)
      else $error("gain stage not bypassed for single-ended input");
   a_gain_diff: assert property (afe_input_sel[5:3] != 3'h0
      && afe_input_sel != `SADC_TEMP_SENSOR
      |-> !afe_gain_bypass && afe_gain_20x == afe_input_sel[0])
      else $error("differential gain does not follow select bit");
   a_temp_route: assert property (afe_temp_sel == (afe_input_sel == `SADC_TEMP_SENSOR))
      else $error("temperature sensor routing wrong");
   a_sel_frozen: assert property (!afe_enable && !$past(afe_enable)
      |-> $stable(afe_input_sel) && $stable(afe_ref_sel))
      else $error("selection changed while disabled");
   a_quiet_off: assert property (!afe_enable && !$past(afe_enable)
      |-> !afe_sample && !conv_done_pulse)
      else $error("conversion activity while disabled");
endmodule

bind sadc_sequencer sadc_seq_chk #(.TRIG_WIDTH(TRIG_WIDTH)) u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .trig_flags(trig_flags), .cmp_result(cmp_result), .afe_ref_sel(afe_ref_sel),
   .afe_input_sel(afe_input_sel), .afe_gain_20x(afe_gain_20x),
   .afe_gain_bypass(afe_gain_bypass), .afe_temp_sel(afe_temp_sel),
   .afe_enable(afe_enable), .afe_sample(afe_sample), .afe_dac_code(afe_dac_code),
   .conv_done_pulse(conv_done_pulse));

/* verification/test_sar_adc_sequencer.sv */
// Self-checking testbench for the converter sequencer
`timescale 1ns/100ps

module test_sar_adc_sequencer;
   logic        sys_clk, rst_n, avs_read, avs_write, cmp_result;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, rd;
   logic [3:0]  avs_byteenable;
   logic [7:0]  trig_flags;
   wire  [31:0] avs_readdata;
   wire  [9:0]  afe_dac_code;
   wire  [5:0]  afe_input_sel;
   wire  [1:0]  afe_ref_sel;
   wire         avs_waitrequest, afe_gain_20x, afe_gain_bypass, afe_temp_sel;
   wire         afe_enable, afe_sample, conv_done_pulse;
   int          mismatches, compares, cyc, n;

   sadc_sequencer #(.TRIG_WIDTH(8)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .trig_flags(trig_flags), .cmp_result(cmp_result), .afe_ref_sel(afe_ref_sel),
      .afe_input_sel(afe_input_sel), .afe_gain_20x(afe_gain_20x),
      .afe_gain_bypass(afe_gain_bypass), .afe_temp_sel(afe_temp_sel),
      .afe_enable(afe_enable), .afe_sample(afe_sample), .afe_dac_code(afe_dac_code),
      .conv_done_pulse(conv_done_pulse));

   always #50 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task end_sim;
      if (mismatches == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard: the whole run needs well under 2000 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         end_sim;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low, takes read data there
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
         end_sim;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // Cycles until the done pulse is seen; lim means it never came
   task wait_done(input int lim);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (conv_done_pulse !== 1'b1 && n < lim);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      // Status word shows the first-conversion flag pending out of reset
      for (int i = 0; i < 7; i++) begin
         bus(0, 5'(4 * i), 0);
         chk(rd, (i == 5) ? 32'h2 : 32'h0);
      end
      avs_byteenable <= 4'hE;
      bus(1, 5'h08, 32'h10);
      avs_byteenable <= 4'hF;
      bus(0, 5'h08, 0);
      chk(rd, 0);
      bus(1, 5'h00, 32'hA2);
      repeat (2) @(posedge sys_clk);
      chk(afe_input_sel, 0);
      chk(afe_temp_sel, 0);
   endtask

   task t_first;
      bus(1, 5'h04, 32'hC0);
      wait_done(80);
      chk(n >= 50 && n <= 54, 1);
      chk(afe_ref_sel, 2);
      chk(afe_temp_sel, 1);
      bus(0, 5'h04, 0);
      chk(rd, 32'h90);
      bus(0, 5'h0C, 0);
      chk(rd, 32'hFF);
      bus(0, 5'h10, 0);
      chk(rd, 32'h03);
      bus(1, 5'h04, 32'h90);
      bus(0, 5'h04, 0);
      chk(rd, 32'h80);
   endtask

   task t_left_lock;
      bus(1, 5'h08, 32'h10);
      bus(1, 5'h04, 32'hC0);
      wait_done(60);
      chk(n >= 26 && n <= 30, 1);
      bus(0, 5'h0C, 0);
      chk(rd, 32'hC0);
      cmp_result <= 1'b0;
      bus(1, 5'h04, 32'hC0);
      bus(1, 5'h00, 32'h83);
      chk(afe_input_sel, 6'h22);
      bus(0, 5'h04, 0);
      chk(rd[6], 1);
      wait_done(60);
      chk(n < 60, 1);
      repeat (3) @(posedge sys_clk);
      chk(afe_input_sel, 6'h03);
      bus(0, 5'h10, 0);
      chk(rd, 32'hFF);
      bus(0, 5'h0C, 0);
      chk(rd, 32'hC0);
   endtask

   task t_auto;
      bus(1, 5'h08, 32'h01);
      bus(1, 5'h00, 32'h89);
      bus(1, 5'h04, 32'hA0);
      repeat (2) @(posedge sys_clk);
      chk(afe_gain_20x, 1);
      trig_flags <= 8'h02;
      wait_done(80);
      chk(n >= 29 && n <= 36, 1);
      wait_done(120);
      chk(n, 120);
      bus(1, 5'h04, 32'hE0);
      bus(0, 5'h04, 0);
      chk(rd[6], 1);
      wait_done(60);
      chk(n < 60, 1);
      trig_flags <= 8'h00;
      repeat (2) @(posedge sys_clk);
      trig_flags <= 8'h02;
      wait_done(80);
      chk(n < 80, 1);
      trig_flags <= 8'h00;
   endtask

   task t_free;
      int k;
      k = 0;
      bus(1, 5'h08, 32'h00);
      bus(1, 5'h04, 32'hE0);
      repeat (200) begin
         @(posedge sys_clk);
         if (conv_done_pulse === 1'b1)
            k++;
      end
      chk(k >= 6 && k <= 8, 1);
      bus(0, 5'h04, 0);
      chk(rd[6], 1);
      bus(1, 5'h04, 32'h00);
      k = 0;
      repeat (100) begin
         @(posedge sys_clk);
         if (conv_done_pulse === 1'b1)
            k++;
      end
      chk(k, 0);
      chk(afe_enable, 0);
   endtask

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      trig_flags = 8'h00;
      cmp_result = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset;
      t_first;
      t_left_lock;
      t_auto;
      t_free;
      end_sim;
   end
endmodule
